// *** include/ndsr_consts.svh ***
/*
 * Constants of the nibble data space and data ROM reader:
 * register offsets, field positions, reset values, sizes and timing.
 * Assumes it is included by bare name, once or more.
 */
`ifndef NDSR_CONSTS_SVH
`define NDSR_CONSTS_SVH

// ============================================================
// Direct address map of the common block
`define NDSR_OFS_FLAG_STATUS    6'h00
`define NDSR_OFS_RSVD_A         6'h01
`define NDSR_OFS_PA_DIRECTION   6'h02
`define NDSR_OFS_PA_PINS        6'h03
`define NDSR_OFS_RSVD_B_FIRST   6'h04
`define NDSR_OFS_RSVD_B_LAST    6'h06
`define NDSR_OFS_SCRATCH_ONE    6'h07
`define NDSR_OFS_SCRATCH_TWO    6'h0f
`define NDSR_OFS_ROM_ADDR0      6'h18
`define NDSR_OFS_ROM_ADDR1      6'h19
`define NDSR_OFS_ROM_ADDR2      6'h1a
`define NDSR_OFS_ROM_ADDR3      6'h1b
`define NDSR_OFS_ROM_DATA_LOW   6'h1c
`define NDSR_OFS_ROM_DATA_HIGH  6'h1d
`define NDSR_OFS_ROM_ADDR4      6'h1e
`define NDSR_BITOP_LIMIT        6'h10
`define NDSR_SRAM_WINDOW_BIT    5

// ============================================================
// Flag status fields and reset values
`define NDSR_STAT_ZERO_BIT      0
`define NDSR_STAT_CARRY_BIT     1
`define NDSR_STAT_PWM_IRQ_BIT   2
`define NDSR_STAT_RESET         4'h0
`define NDSR_PA_DIR_RESET       4'h0
`define NDSR_NIBBLE_RESET       4'h0
`define NDSR_PAGE_RESET         2'h0

// ============================================================
// SRAM and data ROM sizes
`define NDSR_SRAM_NIBBLES       96
`define NDSR_SRAM_PAGE_SIZE     32
`define NDSR_SRAM_PAGES         2'h3
`define NDSR_ROM_LIMIT_4K       20'h1e000
`define NDSR_ROM_LIMIT_8K       20'h1c000
`define NDSR_ROM_SYSTEM_SIZE    20'h00040
`define NDSR_ROM_BLANK          8'hff

// ============================================================
// Data ready time: longest time in ns, cycles at 50 MHz
`define NDSR_CLK_PERIOD_NS      20
`define NDSR_DATA_READY_NS      40
`define NDSR_DATA_READY_CYCLES  (`NDSR_DATA_READY_NS / `NDSR_CLK_PERIOD_NS)

`endif

// *** include/ndsr_pkg.sv ***
/*
 * Types of the nibble data space and data ROM reader.
 * Assumes the constants header sits beside it in include/.
 */
package ndsr_pkg;

    // ============================================================
    // One access from the processor core in one cycle
    typedef struct packed {
        logic [5:0] addr;      // Direct or indirect nibble address
        logic       wr;        // Load or ALU result write
        logic       rd;        // Load or ALU operand read
        logic       bit_set;   // Single-bit set
        logic       bit_clr;   // Single-bit clear
        logic [1:0] bit_idx;   // Bit for set or clear
        logic       indirect;  // Address came through indirect mode
        logic [3:0] wdata;     // Write data
    } ndsr_req_type;

    // ============================================================
    // Flag update from the core's ALU
    typedef struct packed {
        logic we;              // Update carry and zero this cycle
        logic carry;           // New carry
        logic zero;            // New zero
    } ndsr_alu_flags_type;

endpackage : ndsr_pkg

// *** verilog/ndsr_data_space.sv ***
/*
 * Data space of a 4-bit processor: common special-register block at
 * 00H-1FH, paged 96-nibble SRAM at 20H-3FH, and the indirect read port
 * into the 8-bit data ROM.
 * Assumes one 50 MHz clock, an asynchronous active-low reset, a core
 * that issues at most one access per cycle, and a data ROM array that
 * answers combinationally to the address it is given.
 * Limits: the ROM byte trails the address by one edge, so a read of
 * 1CH or 1DH belongs two edges after the last address write. A page
 * load serves accesses from the next edge on. Page 3 is empty.
 */
`timescale 1ns/1ns
`include "ndsr_consts.svh"
`default_nettype none

module ndsr_data_space (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    arst_n_in,

    // Core side
    input  wire ndsr_pkg::ndsr_req_type  core_req_in,
    input  wire ndsr_pkg::ndsr_alu_flags_type alu_flags_in,
    input  wire logic                    page_load_in,
    input  wire logic [1:0]              page_value_in,
    input  wire logic                    pwm_irq_set_in,

    // Options, pins and array
    input  wire logic                    program_rom_8k_in,
    input  wire logic                    wdt_enable_in,
    input  wire logic [3:0]              port_a_lines_in,
    input  wire logic [7:0]              rom_data_in,

    // Registered outputs
    output logic      [3:0]              rd_data_out,
    output logic      [3:0]              flag_status_out,
    output logic      [3:0]              port_a_lines_out,
    output logic      [3:0]              port_a_lines_oe_out,
    output logic      [19:0]             rom_addr_out,
    output logic                         wdt_restart_out
);
    import ndsr_pkg::*;

    // ============================================================
    // Register storage
    // Special registers
    logic [3:0]  flag_status_reg;          // Status: irq, carry, zero
    logic [3:0]  port_a_direction_reg;     // One bit per line, 1 = output
    logic [3:0]  port_a_latch_reg;         // Output latch of port A
    logic [3:0]  scratch_one_reg;          // General nibble at 07H
    logic [3:0]  scratch_two_reg;          // General nibble at 0FH

    // Data ROM port
    logic [3:0]  rom_addr_reg [0:4];       // Address nibbles, lowest first
    logic [7:0]  rom_byte_reg;             // Captured data ROM byte

    // Paging, answers and SRAM
    logic [1:0]  page_select_reg;          // SRAM page
    logic [3:0]  rd_data_reg;              // Read answer to the core
    logic        wdt_restart_reg;          // Watchdog restart pulse
    logic [3:0]  sram_mem [0:`NDSR_SRAM_NIBBLES-1]; // Paged SRAM

    // ============================================================
    // Access decode
    logic        in_sram;                  // Address lies in 20H-3FH
    logic        page_valid;               // Selected page exists
    logic [6:0]  sram_index;               // Flat SRAM entry index

    // Write path
    logic        bitop_ok;                 // Bit op permitted here
    logic        do_write;                 // Any write lands this cycle
    logic [3:0]  cur_value;                // Current value at address
    logic [3:0]  wr_value;                 // Value after write or bit op

    // Data ROM address and capacity
    logic [19:0] rom_addr_full;            // Joined address nibbles
    logic [19:0] rom_limit;                // Capacity of selected option

    // Top half of the direct space is SRAM whatever the page
    assign in_sram = core_req_in.addr[`NDSR_SRAM_WINDOW_BIT];

    // Only pages 0 to 2 hold SRAM
    assign page_valid = (page_select_reg < `NDSR_SRAM_PAGES);

    // Page times page size plus offset in page
    assign sram_index = {page_select_reg, core_req_in.addr[4:0]};

    // Direct bit ops stop at 0FH; indirect may reach any address
    // A refused bit op is dropped whole, with no partial write
    assign bitop_ok = core_req_in.indirect
                    || (core_req_in.addr < `NDSR_BITOP_LIMIT);

    // Load, ALU write, or an allowed bit op
    assign do_write = core_req_in.wr
                    || ((core_req_in.bit_set || core_req_in.bit_clr) && bitop_ok);

    // Highest nibble first
    assign rom_addr_full = {rom_addr_reg[4], rom_addr_reg[3], rom_addr_reg[2],
                            rom_addr_reg[1], rom_addr_reg[0]};

    // Capacity depends on program ROM size; system area not blocked
    // Past the limit the capture stores the blank value
    assign rom_limit = program_rom_8k_in ? `NDSR_ROM_LIMIT_8K : `NDSR_ROM_LIMIT_4K;

    // ============================================================
    // Read multiplexer, also the operand of bit operations
    always_comb begin
        cur_value = 4'h0;                  // Reserved and unused read zero

        // SRAM window first, then the common block
        if (in_sram) begin
            // Missing page reads zero
            if (page_valid) begin
                cur_value = sram_mem[sram_index];
            end
        end else begin
            // Common block, whatever the page
            unique case (core_req_in.addr)
                `NDSR_OFS_FLAG_STATUS:   cur_value = flag_status_reg;
                `NDSR_OFS_PA_DIRECTION:  cur_value = port_a_direction_reg;
                `NDSR_OFS_PA_PINS:       cur_value = port_a_lines_in;
                `NDSR_OFS_SCRATCH_ONE:   cur_value = scratch_one_reg;
                `NDSR_OFS_SCRATCH_TWO:   cur_value = scratch_two_reg;
                `NDSR_OFS_ROM_ADDR0:     cur_value = rom_addr_reg[0];
                `NDSR_OFS_ROM_ADDR1:     cur_value = rom_addr_reg[1];
                `NDSR_OFS_ROM_ADDR2:     cur_value = rom_addr_reg[2];
                `NDSR_OFS_ROM_ADDR3:     cur_value = rom_addr_reg[3];
                `NDSR_OFS_ROM_ADDR4:     cur_value = rom_addr_reg[4];
                `NDSR_OFS_ROM_DATA_LOW:  cur_value = rom_byte_reg[3:0];
                `NDSR_OFS_ROM_DATA_HIGH: cur_value = rom_byte_reg[7:4];
                // Reserved slots and blocks outside this design
                default:                 cur_value = 4'h0;
            endcase
        end
    end

    // ============================================================
    // Value to store: plain write data, or operand with one bit changed
    always_comb begin
        wr_value = core_req_in.wdata;

        // A plain write wins; bit ops use bit_idx, not wdata
        if (!core_req_in.wr && core_req_in.bit_set) begin
            // Set the chosen bit
            wr_value = cur_value | (4'h1 << core_req_in.bit_idx);
        end else if (!core_req_in.wr && core_req_in.bit_clr) begin
            // Clear the chosen bit
            wr_value = cur_value & ~(4'h1 << core_req_in.bit_idx);
        end
    end

    // ============================================================
    // Read answer, one cycle after the request
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // Zero until the first read
            rd_data_reg <= 4'h0;
        end else if (core_req_in.rd) begin
            // Hold last answer between reads
            rd_data_reg <= cur_value;
        end
    end

    // ============================================================
    // Flag status register
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flag_status_reg <= `NDSR_STAT_RESET;
        end else begin
            // Statement order gives priority, last wins: event, then ALU, then bus

            // Bus write of the three flags; top bit stays zero
            if (do_write && !in_sram && core_req_in.addr == `NDSR_OFS_FLAG_STATUS) begin
                flag_status_reg[2:0] <= wr_value[2:0];
            end

            // ALU result overrides a bus write of carry and zero
            if (alu_flags_in.we) begin
                flag_status_reg[`NDSR_STAT_CARRY_BIT] <= alu_flags_in.carry;
                flag_status_reg[`NDSR_STAT_ZERO_BIT]  <= alu_flags_in.zero;
            end

            // Interrupt event wins over a clear in the same cycle
            if (pwm_irq_set_in) begin
                flag_status_reg[`NDSR_STAT_PWM_IRQ_BIT] <= 1'b1;
            end
        end
    end

    // ============================================================
    // Port A direction and output latch
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // All lines start as inputs
            port_a_direction_reg <= `NDSR_PA_DIR_RESET;
            port_a_latch_reg     <= `NDSR_NIBBLE_RESET;
        end else if (do_write && !in_sram) begin
            // Direction register
            if (core_req_in.addr == `NDSR_OFS_PA_DIRECTION) begin
                port_a_direction_reg <= wr_value;
            end

            // Data writes reach the latch only
            if (core_req_in.addr == `NDSR_OFS_PA_PINS) begin
                port_a_latch_reg <= wr_value;
            end
        end
    end

    // ============================================================
    // Two scratch nibbles in the special-register block
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // Flops, not SRAM: page changes leave them alone
            scratch_one_reg <= `NDSR_NIBBLE_RESET;
            scratch_two_reg <= `NDSR_NIBBLE_RESET;
        end else if (do_write && !in_sram) begin
            // Scratch at 07H
            if (core_req_in.addr == `NDSR_OFS_SCRATCH_ONE) begin
                scratch_one_reg <= wr_value;
            end

            // Scratch at 0FH
            if (core_req_in.addr == `NDSR_OFS_SCRATCH_TWO) begin
                scratch_two_reg <= wr_value;
            end
        end
    end

    // ============================================================
    // Data ROM address nibbles, one per register
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gen_rom_addr
            // Offset of this nibble: 18H-1BH, then 1EH
            localparam logic [5:0] NIB_OFS = (g == 4) ? `NDSR_OFS_ROM_ADDR4
                                           : 6'(`NDSR_OFS_ROM_ADDR0 + g);
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    // Zero address after reset
                    rom_addr_reg[g] <= `NDSR_NIBBLE_RESET;
                end else if (do_write && !in_sram && core_req_in.addr == NIB_OFS) begin
                    rom_addr_reg[g] <= wr_value;
                end
            end
        end
    endgenerate

    // ============================================================
    // Data ROM byte capture: ready one edge after the address settles
    // Registered so the array path stays off the read multiplexer;
    // the cost is one edge, inside the two-cycle ready time
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // Blank until the first capture
            rom_byte_reg <= `NDSR_ROM_BLANK;
        end else if (rom_addr_full < rom_limit) begin
            // Within capacity, system area included
            rom_byte_reg <= rom_data_in;
        end else begin
            // Beyond the array: blank OTP value
            rom_byte_reg <= `NDSR_ROM_BLANK;
        end
    end

    // ============================================================
    // Watchdog restart on a write to the high data nibble
    // The high nibble itself is never written by the core
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // No pulse out of reset
            wdt_restart_reg <= 1'b0;
        end else begin
            // Pulse only while the watchdog option is on
            wdt_restart_reg <= do_write && !in_sram && wdt_enable_in
                            && core_req_in.addr == `NDSR_OFS_ROM_DATA_HIGH;
        end
    end

    // Writes to 1CH and to reserved slots fall through every process above
    // without a match, so they store nothing.

    // ============================================================
    // Page select, loaded only by the page-load instruction
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // Page 0 until software loads one
            page_select_reg <= `NDSR_PAGE_RESET;
        end else if (page_load_in) begin
            page_select_reg <= page_value_in;
        end
    end

    // ============================================================
    // SRAM entries: no reset, contents start unknown
    // Page 3 indexes past the array and matches no entry
    generate
        for (g = 0; g < `NDSR_SRAM_NIBBLES; g = g + 1) begin : gen_sram
            always_ff @(posedge clk_in) begin
                // Write only when the selected page exists
                if (do_write && in_sram && page_valid && sram_index == 7'(g)) begin
                    sram_mem[g] <= wr_value;
                end
            end
        end
    endgenerate

    // ============================================================
    // Outputs, each straight from a flip-flop
    // Address output is the five nibble flops side by side
    assign rd_data_out         = rd_data_reg;
    assign flag_status_out     = flag_status_reg;
    assign port_a_lines_out    = port_a_latch_reg;
    assign port_a_lines_oe_out = port_a_direction_reg;
    assign rom_addr_out        = rom_addr_full;
    assign wdt_restart_out     = wdt_restart_reg;

endmodule : ndsr_data_space

`default_nettype wire

// *** bench/ndsr_rom_model.sv ***
/*
 * Behavioural data ROM array on the far side of the reader.
 * Assumes the reader presents a 20-bit byte address and takes the byte back combinationally.
 */
`timescale 1ns/1ns
`default_nettype none

module ndsr_rom_model (
    input  wire logic [19:0] rom_addr_in,
    output logic      [7:0]  rom_data_out
);
    // ============================================================
    // Content pattern
    // Halves differ at 0A5C3H and 1BFFFH, so swapped nibbles fail there; at 1DFC0H both are 6
    function automatic logic [7:0] byte_at(input logic [19:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ {4'h0, a[19:16]} ^ 8'h5a;
    endfunction : byte_at

    // Array answers with no latency
    assign rom_data_out = byte_at(rom_addr_in);
endmodule : ndsr_rom_model
`default_nettype wire

// *** bench/ndsr_data_space_properties.sv ***
/*
 * Port checker for the nibble data space.
 * Assumes a bind to ndsr_data_space and one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module ndsr_data_space_properties (
    input  wire logic                         clk_in,
    input  wire logic                         arst_n_in,
    input  wire ndsr_pkg::ndsr_req_type       core_req_in,
    input  wire ndsr_pkg::ndsr_alu_flags_type alu_flags_in,
    input  wire logic                         page_load_in,
    input  wire logic [1:0]                   page_value_in,
    input  wire logic                         pwm_irq_set_in,
    input  wire logic                         program_rom_8k_in,
    input  wire logic                         wdt_enable_in,
    input  wire logic [3:0]                   port_a_lines_in,
    input  wire logic [7:0]                   rom_data_in,
    input  wire logic [3:0]                   rd_data_out,
    input  wire logic [3:0]                   flag_status_out,
    input  wire logic [3:0]                   port_a_lines_out,
    input  wire logic [3:0]                   port_a_lines_oe_out,
    input  wire logic [19:0]                  rom_addr_out,
    input  wire logic                         wdt_restart_out
);
    import ndsr_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    logic [7:0] rom_seen_q; // ROM byte one edge back

    // ============================================================
    // Helper logic
    // Delays the array answer to line up with a read result
    always_ff @(posedge clk_in) begin
        rom_seen_q <= rom_data_in;
    end

    // ============================================================
    // Sequences
    sequence wdt_kick_s;
        wdt_enable_in && core_req_in.wr && core_req_in.addr == 6'h1d;
    endsequence
    sequence rom_settled_read_s;
        $stable(rom_addr_out) ##1 ($stable(rom_addr_out) && $past(arst_n_in, 2)
            && rom_addr_out < 20'h1c000 && core_req_in.rd && core_req_in.addr[5:1] == 5'h0e);
    endsequence

    // ============================================================
    // Assertions
    wdt_pulse_a: assert property (wdt_kick_s |=> wdt_restart_out)
        else $error("watchdog restart missing after high data write");
    wdt_cause_a: assert property (wdt_restart_out |-> $past(wdt_enable_in)
        && $past(core_req_in.addr) == 6'h1d && $past(core_req_in.wr | core_req_in.bit_set
        | core_req_in.bit_clr)) else $error("watchdog restart without cause");
    rom_nibble_read_a: assert property (rom_settled_read_s |=> rd_data_out ==
        ($past(core_req_in.addr[0]) ? rom_seen_q[7:4] : rom_seen_q[3:0]))
        else $error("data nibble differs from addressed ROM byte");
    rom_addr_low_a: assert property (core_req_in.wr && core_req_in.addr == 6'h18
        |=> rom_addr_out[3:0] == $past(core_req_in.wdata)) else $error("low address nibble");
    rom_addr_top_a: assert property (core_req_in.wr && core_req_in.addr == 6'h1e
        |=> rom_addr_out[19:16] == $past(core_req_in.wdata)) else $error("top address nibble");
    pwm_flag_set_a: assert property (pwm_irq_set_in |=> flag_status_out[2])
        else $error("pwm flag not set");
    alu_flags_a: assert property (alu_flags_in.we |=> flag_status_out[1:0] ==
        {$past(alu_flags_in.carry), $past(alu_flags_in.zero)}) else $error("alu flags lost");
    dir_hold_a: assert property (!((core_req_in.wr | core_req_in.bit_set | core_req_in.bit_clr)
        && core_req_in.addr == 6'h02) |=> $stable(port_a_lines_oe_out))
        else $error("direction changed without write");
    port_read_a: assert property (core_req_in.rd && core_req_in.addr == 6'h03
        |=> rd_data_out == $past(port_a_lines_in)) else $error("port read not pin levels");
endmodule : ndsr_data_space_properties

bind ndsr_data_space ndsr_data_space_properties u_props (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .core_req_in(core_req_in),
    .alu_flags_in(alu_flags_in), .page_load_in(page_load_in), .page_value_in(page_value_in),
    .pwm_irq_set_in(pwm_irq_set_in), .program_rom_8k_in(program_rom_8k_in), .wdt_enable_in(wdt_enable_in),
    .port_a_lines_in(port_a_lines_in), .rom_data_in(rom_data_in), .rd_data_out(rd_data_out),
    .flag_status_out(flag_status_out), .port_a_lines_out(port_a_lines_out),
    .port_a_lines_oe_out(port_a_lines_oe_out), .rom_addr_out(rom_addr_out),
    .wdt_restart_out(wdt_restart_out));
`default_nettype wire

// *** bench/nibble_data_space_rom_reader_tb.sv ***
/*
 * Self-checking bench of the nibble data space with a data ROM model.
 * Assumes the design, package, ROM model and checker are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none

module nibble_data_space_rom_reader_tb;
    import ndsr_pkg::*;
    localparam logic [4:0] k_wr = 5'h01, k_rd = 5'h02, k_set = 5'h04, k_clr = 5'h08, k_ind = 5'h10;
    logic               clk_in, arst_n_in, page_load_in, pwm_irq_set_in, program_rom_8k_in;
    logic               wdt_enable_in, wdt_restart;
    ndsr_req_type       core_req_in;
    ndsr_alu_flags_type alu_flags_in;
    logic [1:0]         page_value_in;
    logic [3:0]         port_a_lines_in, rd_data, flag_status, pa_out, pa_oe;
    logic [7:0]         rom_data, exp_b;
    logic [19:0]        rom_addr;
    int                 n_mismatch, tests_run;
    logic [5:0]         adr_tab [5] = '{6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1e};
    logic [5:0]         rw_tab [8] = '{6'h02, 6'h07, 6'h0f, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1e};
    logic [5:0]         rsv_tab [5] = '{6'h01, 6'h04, 6'h05, 6'h06, 6'h1f};
    logic [19:0]        rom_tab [4] = '{20'h0a5c3, 20'h1dfc0, 20'h1dfc0, 20'h1bfff};
    logic               opt_tab [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

    ndsr_data_space u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .core_req_in(core_req_in),
        .alu_flags_in(alu_flags_in), .page_load_in(page_load_in), .page_value_in(page_value_in),
        .pwm_irq_set_in(pwm_irq_set_in), .program_rom_8k_in(program_rom_8k_in), .wdt_enable_in(wdt_enable_in),
        .port_a_lines_in(port_a_lines_in), .rom_data_in(rom_data), .rd_data_out(rd_data),
        .flag_status_out(flag_status), .port_a_lines_out(pa_out), .port_a_lines_oe_out(pa_oe),
        .rom_addr_out(rom_addr), .wdt_restart_out(wdt_restart));
    ndsr_rom_model u_rom (.rom_addr_in(rom_addr), .rom_data_out(rom_data));

    // ============================================================
    // Clock and tasks
    always #10 clk_in = ~clk_in;

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One access held until its taking edge
    task automatic acc(input logic [5:0] a, input logic [4:0] k, input logic [3:0] d);
        core_req_in <= '{addr: a, wr: k[0], rd: k[1], bit_set: k[2], bit_clr: k[3],
                         bit_idx: d[1:0], indirect: k[4], wdata: d};
        @(posedge clk_in);
    endtask : acc
    task automatic idle(input int n);
        core_req_in <= '0;
        repeat (n) @(posedge clk_in);
    endtask : idle
    task automatic rd_chk(input string what, input logic [5:0] a, input logic [3:0] exp);
        acc(a, k_rd, 4'h0);
        idle(1);
        chk(what, 20'(exp), 20'(rd_data));
    endtask : rd_chk
    task automatic set_addr(input logic [19:0] v);
        for (int i = 0; i < 5; i++) acc(adr_tab[i], k_wr, v[4*i +: 4]);
    endtask : set_addr
    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // ============================================================
    // Hang limit
    initial begin
        repeat (3000) @(posedge clk_in);
        n_mismatch++;
        $display("ERROR run limit expected end seen running");
        conclude();
    end

    // ============================================================
    // Main sequence
    initial begin
        clk_in = 1'b0; arst_n_in = 1'b0; core_req_in = '0; alu_flags_in = '0;
        page_load_in = 1'b0; page_value_in = 2'h0; pwm_irq_set_in = 1'b0; program_rom_8k_in = 1'b0;
        wdt_enable_in = 1'b1; port_a_lines_in = 4'h6; n_mismatch = 0; tests_run = 0;
        repeat (3) @(posedge clk_in);
        arst_n_in <= 1'b1;
        chk("direction reset", 20'h0, 20'(pa_oe));
        chk("status reset", 20'h0, 20'(flag_status));
        foreach (rw_tab[i]) acc(rw_tab[i], k_wr, 4'(i + 3));
        foreach (rw_tab[i]) rd_chk("rw register", rw_tab[i], 4'(i + 3));
        foreach (rsv_tab[i]) acc(rsv_tab[i], k_wr, 4'hf);
        chk("rom address", 20'ha9876, rom_addr);
        foreach (rsv_tab[i]) rd_chk("reserved slot", rsv_tab[i], 4'h0);
        for (int i = 0; i < 4; i++) begin
            program_rom_8k_in <= opt_tab[i];
            set_addr(rom_tab[i]);
            idle(1);
            exp_b = (i == 2) ? 8'hff : u_rom.byte_at(rom_tab[i]);
            rd_chk("rom low nibble", 6'h1c, exp_b[3:0]);
            rd_chk("rom high nibble", 6'h1d, exp_b[7:4]);
        end
        acc(6'h1c, k_wr, ~exp_b[3:0]);
        idle(1);
        chk("address after low write", 20'h1bfff, rom_addr);
        rd_chk("low after write", 6'h1c, exp_b[3:0]);
        for (int i = 0; i < 2; i++) begin
            wdt_enable_in <= (i == 0);
            acc(6'h1d, k_wr, 4'h0);
            idle(1);
            chk("watchdog restart", 20'(i == 0), 20'(wdt_restart));
        end
        rd_chk("high after write", 6'h1d, exp_b[7:4]);
        page_load_in <= 1'b1;
        for (int p = 0; p < 8; p++) begin
            page_value_in <= 2'(p);
            idle(1);
            if (p < 4) acc(6'h3f, k_wr, 4'(p + 9));
            else rd_chk("sram page", 6'h3f, (p == 7) ? 4'h0 : 4'(p + 5));
        end
        rd_chk("common block", 6'h07, 4'h4);
        page_load_in <= 1'b0;
        acc(6'h07, k_set, 4'h3);
        acc(6'h18, k_clr, 4'h0);
        acc(6'h19, k_clr | k_ind, 4'h1);
        idle(1);
        chk("bit ops on address", 20'h1bfdf, rom_addr);
        rd_chk("bit set low block", 6'h07, 4'hc);
        acc(6'h02, k_wr, 4'h5);
        acc(6'h03, k_wr, 4'ha);
        idle(1);
        chk("port direction", 20'h5, 20'(pa_oe));
        chk("port latch", 20'ha, 20'(pa_out));
        rd_chk("port pins", 6'h03, 4'h6);
        alu_flags_in <= '{we: 1'b1, carry: 1'b1, zero: 1'b0};
        pwm_irq_set_in <= 1'b1;
        idle(1);
        alu_flags_in <= '0;
        pwm_irq_set_in <= 1'b0;
        idle(1);
        chk("status flags", 20'h6, 20'(flag_status));
        pwm_irq_set_in <= 1'b1;
        acc(6'h00, k_wr, 4'h8);
        pwm_irq_set_in <= 1'b0;
        rd_chk("status write", 6'h00, 4'h4);
        conclude();
    end
endmodule : nibble_data_space_rom_reader_tb
`default_nettype wire
